// file: include/rtdcso_pkg.sv
// Constants and carrier types of the resistance-thermometer channel objects
package rtdcso_pkg;
	// Channel and buffer sizes
	localparam int          NCH           = 8;
	localparam int          NCAL          = 10;
	localparam int          FIFO_DEPTH    = 16;
	// Object index groups
	localparam logic [7:0]  IDX_GRP_INPUT = 8'h60;
	localparam logic [7:0]  IDX_GRP_CFG   = 8'h80;
	localparam logic [3:0]  IDX_LO_INPUT  = 4'h0;
	localparam logic [3:0]  IDX_LO_INTERN = 4'he;
	localparam logic [3:0]  IDX_LO_VENDOR = 4'hf;
	localparam logic [15:0] IDX_PROFILE   = 16'hf000;
	localparam logic [15:0] IDX_CODE_WORD = 16'hf008;
	localparam logic [15:0] IDX_MOD_LIST  = 16'hf010;
	// Subindices
	localparam logic [7:0]  SUB_MAX       = 8'h00;
	localparam logic [7:0]  SUB_UNDER     = 8'h01;
	localparam logic [7:0]  SUB_OVER      = 8'h02;
	localparam logic [7:0]  SUB_ERROR     = 8'h07;
	localparam logic [7:0]  SUB_INVALID   = 8'h0f;
	localparam logic [7:0]  SUB_TOGGLE    = 8'h10;
	localparam logic [7:0]  SUB_VALUE     = 8'h11;
	localparam logic [7:0]  SUB_RAW       = 8'h01;
	localparam logic [7:0]  SUB_RES       = 8'h02;
	localparam logic [7:0]  SUB_CAL_FIRST = 8'h01;
	localparam logic [7:0]  SUB_CAL_LAST  = 8'h0a;
	localparam logic [7:0]  SUB_SPACING   = 8'h01;
	localparam logic [7:0]  SUB_COUNT     = 8'h02;
	// Fixed and reset values
	localparam logic [7:0]  INPUT_MAX_SUB = 8'h11;
	localparam logic [7:0]  INTERN_MAX_SUB = 8'h04;
	localparam logic [7:0]  VENDOR_MAX_SUB = 8'h0a;
	localparam logic [7:0]  PROFILE_MAX_SUB = 8'h02;
	localparam logic [15:0] CHAN_SPACING  = 16'h0010;
	localparam logic [15:0] CHAN_COUNT    = 16'h0008;
	localparam logic [31:0] MODULE_PROFILE = 32'h00000140;
	localparam logic [31:0] CODE_WORD_RST = 32'h00000000;
	localparam logic [15:0] VALUE_RST     = 16'h0000;
	localparam logic [31:0] RAW_RST       = 32'h00000000;
	localparam logic [15:0] CAL_RST       = 16'h0000;

	// One finished conversion from the converter logic
	typedef struct packed {
		logic [2:0]  chan;
		logic        under;
		logic        over;
		logic        error;
		logic [15:0] value;
		logic [31:0] raw;
		logic [15:0] resistance;
	} rtdcso_sample_t;

	// One cyclic input record as handed to the fieldbus side
	typedef struct packed {
		logic [2:0]  chan;
		logic        toggle;
		logic        invalid;
		logic        error;
		logic        over;
		logic        under;
		logic [15:0] value;
	} rtdcso_rec_t;

	// Object access request
	typedef struct packed {
		logic        req;
		logic        wr;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] wdata;
	} rtdcso_obj_req_t;
endpackage

// file: logic/rtdcso_top.sv
// Channel status objects, cyclic record buffer and object access port
//
// Overview of operation
// - Under-range flag set when below range
// - Over-range flag set when above range
// - Over-range plus error means open sensor
// - Error flag follows invalid measurement data
// - Record validity bit: zero valid, one invalid
// - Toggle bit inverts on each record refresh
// - Signed 16-bit value, reset zero, read-only
// - Resistance readback in 1/32 ohm units
// - Writable offset and gain, main and thermistors
// - Four writable reference resistor constants
// - Report channel spacing of sixteen, read-only
// - Report channel count CHANNELS (eight by default), read-only
// - Profile objects fixed meaning for profile
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Record FIFO with registered output stage
module rtdcso_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic             s_valid,
	input  wire logic [WIDTH-1:0] s_data,
	output logic                  s_ready,
	output logic                  m_valid,
	output logic      [WIDTH-1:0] m_data,
	input  wire logic             m_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
			$error("FIFO depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr_q;
	logic [AW-1:0]    rptr_q;
	logic [CW-1:0]    count_q;
	logic [CW-1:0]    count_d;
	logic             ready_q;
	logic             mvalid_q;
	logic [WIDTH-1:0] mdata_q;

	// Handshake terms; the output stage adds one slot beyond DEPTH
	// Ready comes from the next fill level, so it is never late
	wire push = s_valid & ready_q;
	wire load = (count_q != '0) & (~mvalid_q | m_ready);
	assign count_d = count_q + CW'(push) - CW'(load);
	assign s_ready = ready_q;
	assign m_valid = mvalid_q;
	assign m_data  = mdata_q;

	// Storage array
	// Left without reset; the pointers and the fill level say what is valid
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wptr_q] <= s_data;
		end
	end

	// Pointers and fill level; ready is registered
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			count_q <= '0;
			ready_q <= 1'b0;
		end else begin
			wptr_q  <= wptr_q + AW'(push);
			rptr_q  <= rptr_q + AW'(load);
			count_q <= count_d;
			ready_q <= (count_d != CW'(DEPTH));
		end
	end

	// Output stage
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mvalid_q <= 1'b0;
			mdata_q  <= '0;
		end else if (load) begin
			mvalid_q <= 1'b1;
			mdata_q  <= mem[rptr_q];
		end else if (m_ready) begin
			mvalid_q <= 1'b0;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Channel objects top
module rtdcso_top #(
	parameter int CHANNELS = rtdcso_pkg::NCH
) (
	input  wire logic                   mclk,
	input  wire logic                   resetn,
	input  wire logic                   smp_valid,
	input  wire rtdcso_pkg::rtdcso_sample_t smp,
	output logic                        smp_ready,
	output logic                        rec_valid,
	output rtdcso_pkg::rtdcso_rec_t     rec,
	input  wire logic                   rec_ready,
	input  wire rtdcso_pkg::rtdcso_obj_req_t obj,
	output logic                        obj_ack,
	output logic                        obj_err,
	output logic [31:0]                 obj_rdata
);
	import rtdcso_pkg::*;

	generate
		if (CHANNELS < 1 || CHANNELS > NCH) begin : g_chk
			$error("CHANNELS must lie between 1 and 8");
		end
	endgenerate

	// Channel object group match
	function automatic logic chan_obj(input logic [15:0] idx,
	                                  input logic [7:0]  grp,
	                                  input logic [3:0]  lo);
		chan_obj = (idx[15:8] == grp) && (idx[3:0] == lo)
		           && (idx[7:4] < 4'(CHANNELS));
	endfunction

	logic        under_q  [CHANNELS];
	logic        over_q   [CHANNELS];
	logic        err_q    [CHANNELS];
	logic        inv_q    [CHANNELS];
	logic        tog_q    [CHANNELS];
	logic [15:0] value_q  [CHANNELS];
	logic [31:0] raw_q    [CHANNELS];
	logic [15:0] res_q    [CHANNELS];
	logic [15:0] cal_q    [CHANNELS][NCAL];
	logic [31:0] code_q;
	logic        ack_q;
	logic        oerr_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_d;
	logic        rd_ok;
	logic        fifo_ready;
	rtdcso_rec_t push_rec;
	logic [$bits(rtdcso_rec_t)-1:0] fifo_out;

	////////////////////////////////////////////////////////////////////////
	// Sample acceptance and record build
	wire       ch_ok = ({1'b0, smp.chan} < 4'(CHANNELS));
	// Absent channels complete the handshake but change nothing
	wire       acc   = smp_valid & fifo_ready & ch_ok;
	wire [2:0] sch   = smp.chan;

	// Record word formed from the same values as the stored objects
	// Toggle is the inverse of the stored bit, which flips at this edge
	assign push_rec = '{
		chan:    sch,
		toggle:  ~tog_q[sch],
		invalid: smp.error,
		error:   smp.error,
		over:    smp.over,
		under:   smp.under,
		value:   smp.value
	};

	// Records queue up for the fieldbus side
	rtdcso_fifo #(
		.WIDTH ($bits(rtdcso_rec_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk    (mclk),
		.resetn  (resetn),
		.s_valid (acc),
		.s_data  (push_rec),
		.s_ready (fifo_ready),
		.m_valid (rec_valid),
		.m_data  (fifo_out),
		.m_ready (rec_ready)
	);
	assign rec       = rtdcso_rec_t'(fifo_out);
	assign smp_ready = fifo_ready;

	// Record word and objects share one enable, so they always agree
	// Per-channel status objects, all fields in one cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int c = 0; c < CHANNELS; c++) begin
				under_q[c] <= 1'b0;
				over_q[c]  <= 1'b0;
				err_q[c]   <= 1'b0;
				inv_q[c]   <= 1'b0;
				tog_q[c]   <= 1'b0;
				value_q[c] <= VALUE_RST;
				raw_q[c]   <= RAW_RST;
				res_q[c]   <= VALUE_RST;
			end
		end else if (acc) begin
			under_q[sch] <= smp.under;
			over_q[sch]  <= smp.over;
			err_q[sch]   <= smp.error;
			inv_q[sch]   <= smp.error;
			tog_q[sch]   <= ~tog_q[sch];
			value_q[sch] <= smp.value;
			raw_q[sch]   <= smp.raw;
			res_q[sch]   <= smp.resistance;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Object decode
	wire [2:0] och     = obj.index[6:4];
	wire       hit_in  = chan_obj(obj.index, IDX_GRP_INPUT, IDX_LO_INPUT);
	wire       hit_int = chan_obj(obj.index, IDX_GRP_CFG, IDX_LO_INTERN);
	wire       hit_ven = chan_obj(obj.index, IDX_GRP_CFG, IDX_LO_VENDOR);
	wire       cal_sub = (obj.sub >= SUB_CAL_FIRST) && (obj.sub <= SUB_CAL_LAST);
	wire [3:0] cal_ix  = 4'(obj.sub - SUB_CAL_FIRST);
	wire       wr_cal  = obj.req & obj.wr & hit_ven & cal_sub;
	wire       wr_code = obj.req & obj.wr & (obj.index == IDX_CODE_WORD)
	                     & (obj.sub == SUB_MAX);
	wire       mod_sub = (obj.sub != SUB_MAX) && (obj.sub <= 8'(CHANNELS));

	// Read selection; fixed profile objects cannot be changed
	always_comb begin
		rd_d  = '0;
		rd_ok = 1'b1;
		if (hit_in) begin
			unique case (obj.sub)
				SUB_MAX:     rd_d = {24'h000000, INPUT_MAX_SUB};
				SUB_UNDER:   rd_d = {31'h00000000, under_q[och]};
				SUB_OVER:    rd_d = {31'h00000000, over_q[och]};
				SUB_ERROR:   rd_d = {31'h00000000, err_q[och]};
				SUB_INVALID: rd_d = {31'h00000000, inv_q[och]};
				SUB_TOGGLE:  rd_d = {31'h00000000, tog_q[och]};
				SUB_VALUE:   rd_d = {{16{value_q[och][15]}}, value_q[och]};
				default:     rd_ok = 1'b0;
			endcase
		end else if (hit_int) begin
			unique case (obj.sub)
				SUB_MAX: rd_d = {24'h000000, INTERN_MAX_SUB};
				SUB_RAW: rd_d = raw_q[och];
				SUB_RES: rd_d = {16'h0000, res_q[och]};
				default: rd_ok = 1'b0;
			endcase
		end else if (hit_ven) begin
			if (obj.sub == SUB_MAX) begin
				rd_d = {24'h000000, VENDOR_MAX_SUB};
			end else if (cal_sub) begin
				rd_d = {16'h0000, cal_q[och][cal_ix]};
			end else begin
				rd_ok = 1'b0;
			end
		end else if (obj.index == IDX_PROFILE) begin
			unique case (obj.sub)
				SUB_MAX:     rd_d = {24'h000000, PROFILE_MAX_SUB};
				SUB_SPACING: rd_d = {16'h0000, CHAN_SPACING};
				SUB_COUNT:   rd_d = {16'h0000, 16'(CHANNELS)};
				default:     rd_ok = 1'b0;
			endcase
		end else if (obj.index == IDX_CODE_WORD) begin
			rd_d  = code_q;
			rd_ok = (obj.sub == SUB_MAX);
		end else if (obj.index == IDX_MOD_LIST) begin
			if (obj.sub == SUB_MAX) begin
				rd_d = {24'h000000, 8'(CHANNELS)};
			end else if (mod_sub) begin
				rd_d = MODULE_PROFILE;
			end else begin
				rd_ok = 1'b0;
			end
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Writes to read-only or unknown objects are refused
	wire wr_ok = wr_cal | wr_code;

	// Calibration constants and code word
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int c = 0; c < CHANNELS; c++) begin
				for (int k = 0; k < NCAL; k++) begin
					cal_q[c][k] <= CAL_RST;
				end
			end
			code_q <= CODE_WORD_RST;
		end else begin
			if (wr_cal) begin
				cal_q[och][cal_ix] <= obj.wdata[15:0];
			end
			if (wr_code) begin
				code_q <= obj.wdata;
			end
		end
	end

	// Answer one cycle after the request
	// A refused read answers zero so old data is not mistaken for new
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ack_q   <= 1'b0;
			oerr_q  <= 1'b0;
			rdata_q <= '0;
		end else begin
			ack_q  <= obj.req;
			oerr_q <= obj.req & (obj.wr ? ~wr_ok : ~rd_ok);
			if (obj.req & ~obj.wr) begin
				rdata_q <= rd_ok ? rd_d : 32'h00000000;
			end
		end
	end
	assign obj_ack   = ack_q;
	assign obj_err   = oerr_q;
	assign obj_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	// Each check looks one edge after the event that it follows
	AST_UNDER: assert property (@(posedge mclk) disable iff (!resetn)
		acc |=> under_q[$past(sch)] == $past(smp.under))
		else $error("under-range flag not taken");
	AST_OVER: assert property (@(posedge mclk) disable iff (!resetn)
		acc |=> over_q[$past(sch)] == $past(smp.over))
		else $error("over-range flag not taken");
	AST_OPEN: assert property (@(posedge mclk) disable iff (!resetn)
		acc && smp.over && smp.error |=> inv_q[$past(sch)] && err_q[$past(sch)])
		else $error("open sensor not shown as invalid");
	AST_ERROR: assert property (@(posedge mclk) disable iff (!resetn)
		acc |=> err_q[$past(sch)] == $past(smp.error))
		else $error("error flag wrong");
	AST_VALID: assert property (@(posedge mclk) disable iff (!resetn)
		acc |=> inv_q[$past(sch)] == $past(smp.error))
		else $error("validity bit wrong");
	AST_TOGGLE: assert property (@(posedge mclk) disable iff (!resetn)
		acc |=> tog_q[$past(sch)] != $past(tog_q[sch]))
		else $error("toggle did not invert");
	AST_VALUE: assert property (@(posedge mclk) disable iff (!resetn)
		acc |=> value_q[$past(sch)] == $past(smp.value))
		else $error("value not updated");
	AST_SPACING: assert property (@(posedge mclk) disable iff (!resetn)
		obj.req && !obj.wr && obj.index == IDX_PROFILE && obj.sub == SUB_SPACING
		|=> obj_ack && !obj_err && obj_rdata == 32'h00000010)
		else $error("channel spacing misreported");
	AST_COUNT: assert property (@(posedge mclk) disable iff (!resetn)
		obj.req && !obj.wr && obj.index == IDX_PROFILE && obj.sub == SUB_COUNT
		|=> obj_rdata == 32'(CHANNELS))
		else $error("channel count misreported");
	AST_ROWR: assert property (@(posedge mclk) disable iff (!resetn)
		obj.req && obj.wr && obj.index == IDX_PROFILE |=> obj_err)
		else $error("profile object accepted a write");
	AST_ATOMIC: assert property (@(posedge mclk) disable iff (!resetn)
		acc |=> under_q[$past(sch)] == $past(smp.under)
		        && over_q[$past(sch)] == $past(smp.over)
		        && inv_q[$past(sch)] == $past(push_rec.invalid)
		        && tog_q[$past(sch)] == $past(push_rec.toggle)
		        && value_q[$past(sch)] == $past(push_rec.value))
		else $error("channel record not updated as one");
	AST_RES: assert property (@(posedge mclk) disable iff (!resetn)
		acc |=> res_q[$past(sch)] == $past(smp.resistance))
		else $error("resistance not updated");
	AST_CALWR: assert property (@(posedge mclk) disable iff (!resetn)
		wr_cal |=> cal_q[$past(och)][$past(cal_ix)]
		           == $past(obj.wdata[15:0]))
		else $error("calibration constant not written");
	AST_ROVAL: assert property (@(posedge mclk) disable iff (!resetn)
		obj.req && obj.wr && hit_in |=> obj_ack && obj_err)
		else $error("input object accepted a write");
endmodule

`default_nettype wire

// file: testbench/rtdcso_master_model.sv
// Fieldbus master model that drains cyclic input records
`timescale 1ns/1ps
`default_nettype none

module rtdcso_master_model (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic hold,
	input  wire logic rec_valid,
	output logic      rec_ready
);
	// Random acceptance pace, fully stalled while held off
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			rec_ready <= 1'b0;
		else
			rec_ready <= !hold && ($urandom_range(3) != 0);
	end
endmodule

`default_nettype wire

// file: testbench/test_rtd_channel_status_objects.sv
// Self-checking bench for the channel status objects
`timescale 1ns/1ps
`default_nettype none

module test_rtd_channel_status_objects;
	import rtdcso_pkg::*;
	logic            mclk, resetn, smp_valid, smp_ready, hold;
	logic            rec_valid, rec_ready, obj_ack, obj_err;
	logic [31:0]     obj_rdata, d;
	rtdcso_sample_t  smp, s;
	rtdcso_rec_t     rec;
	rtdcso_obj_req_t obj;
	int              n_errors, tests_run, cycles;
	rtdcso_rec_t     exp_q[$];
	rtdcso_sample_t  last[NCH];
	logic            tog[NCH];

	rtdcso_top #(.CHANNELS(NCH)) DUT (.mclk(mclk), .resetn(resetn),
		.smp_valid(smp_valid), .smp(smp), .smp_ready(smp_ready),
		.rec_valid(rec_valid), .rec(rec), .rec_ready(rec_ready),
		.obj(obj), .obj_ack(obj_ack), .obj_err(obj_err),
		.obj_rdata(obj_rdata));
	rtdcso_master_model PARTNER (.mclk(mclk), .resetn(resetn), .hold(hold),
		.rec_valid(rec_valid), .rec_ready(rec_ready));

	////////////////////////////////////////////////////////////////////////
	// Clock, timeout and verdict
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic summarize();
		if (n_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Comparison, expectation and access helpers
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic rtdcso_rec_t exp_rec(rtdcso_sample_t x, logic t);
		exp_rec = '{chan: x.chan, toggle: t, invalid: x.error,
			error: x.error, over: x.over, under: x.under, value: x.value};
	endfunction
	function automatic logic [15:0] ix(logic [7:0] g, int n, logic [3:0] lo);
		ix = {g, 4'(n), lo};
	endfunction
	// One object access, answer checked one cycle later; req left to caller
	task automatic acc(logic w, logic [15:0] i, logic [7:0] sb,
		logic [31:0] wd, logic [31:0] ex, logic ee);
		obj = '{req: 1'b1, wr: w, index: i, sub: sb, wdata: wd};
		@(negedge mclk);
		chk("obj_ack", 32'h1, {31'h0, obj_ack});
		chk("obj_err", {31'h0, ee}, {31'h0, obj_err});
		if (!w)
			chk("obj_rdata", ex, obj_rdata);
	endtask
	// Offer a sample and hold it until taken
	task automatic send(rtdcso_sample_t x);
		int w;
		smp = x;
		smp_valid = 1'b1;
		w = 0;
		while (smp_ready !== 1'b1 && w < 100) begin
			@(negedge mclk);
			w++;
		end
		chk("smp_taken", 32'h1, {31'h0, smp_ready});
		tog[x.chan] = ~tog[x.chan];
		last[x.chan] = x;
		exp_q.push_back(exp_rec(x, tog[x.chan]));
		@(negedge mclk);
	endtask
	function automatic rtdcso_sample_t rnd();
		logic [127:0] r;
		r = {$urandom, $urandom, $urandom, $urandom};
		rnd = r[$bits(rtdcso_sample_t)-1:0];
	endfunction
	task automatic drain();
		int w;
		w = 0;
		while (exp_q.size() != 0 && w < 2000) begin
			@(negedge mclk);
			w++;
		end
		chk("records_left", 32'h0, 32'(exp_q.size()));
		repeat (2) @(negedge mclk);
		chk("rec_valid_idle", 32'h0, {31'h0, rec_valid});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Record monitor: every taken record matches the next expected one
	always @(negedge mclk) begin
		if (resetn && rec_valid === 1'b1 && rec_ready === 1'b1) begin
			if (exp_q.size() == 0)
				chk("rec_unexpected", 32'h0, 32'h1);
			else
				chk("rec", 32'(exp_q[0]), 32'(rec));
			if (exp_q.size() != 0)
				void'(exp_q.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'h732f));
		resetn = 1'b0;
		smp_valid = 1'b0;
		smp = '0;
		obj = '0;
		hold = 1'b0;
		d = '0;
		s = '0;
		n_errors = 0;
		tests_run = 0;
		cycles = 0;
		for (int n = 0; n < NCH; n++) begin
			tog[n] = 1'b0;
			last[n] = '0;
		end
		repeat (5) @(negedge mclk);
		resetn = 1'b1;
		repeat (2) @(negedge mclk);
		// Profile objects, module list and refusals
		acc(0, IDX_PROFILE, 8'h00, 0, 32'h2, 0);
		acc(0, IDX_PROFILE, 8'h01, 0, 32'h10, 0);
		acc(0, IDX_PROFILE, 8'h02, 0, 32'h8, 0);
		acc(1, IDX_PROFILE, 8'h01, 32'h55, 0, 1);
		acc(0, IDX_PROFILE, 8'h01, 0, 32'h10, 0);
		acc(1, IDX_PROFILE, 8'h02, 32'h3, 0, 1);
		acc(0, IDX_MOD_LIST, 8'h00, 0, 32'h8, 0);
		for (int k = 1; k <= NCH; k++)
			acc(0, IDX_MOD_LIST, 8'(k), 0, 32'h140, 0);
		acc(0, IDX_CODE_WORD, 8'h00, 0, 32'h0, 0);
		d = $urandom;
		acc(1, IDX_CODE_WORD, 8'h00, d, 0, 0);
		acc(0, IDX_CODE_WORD, 8'h00, 0, d, 0);
		acc(0, ix(IDX_GRP_INPUT, NCH, 4'h0), 8'h11, 0, 0, 1);
		acc(0, ix(IDX_GRP_INPUT, 0, 4'h0), 8'h03, 0, 0, 1);
		// Per channel reset values and calibration constants
		for (int n = 0; n < NCH; n++) begin
			acc(0, ix(IDX_GRP_INPUT, n, 4'h0), 8'h00, 0, 32'h11, 0);
			acc(0, ix(IDX_GRP_INPUT, n, 4'h0), 8'h11, 0, 32'h0, 0);
			acc(0, ix(IDX_GRP_INPUT, n, 4'h0), 8'h10, 0, 32'h0, 0);
			acc(0, ix(IDX_GRP_INPUT, n, 4'h0), 8'h07, 0, 32'h0, 0);
			acc(0, ix(IDX_GRP_INPUT, n, 4'h0), 8'h0f, 0, 32'h0, 0);
			acc(1, ix(IDX_GRP_INPUT, n, 4'h0), 8'h11, 32'h7, 0, 1);
			acc(0, ix(IDX_GRP_CFG, n, 4'he), 8'h00, 0, 32'h4, 0);
			acc(0, ix(IDX_GRP_CFG, n, 4'he), 8'h02, 0, 32'h0, 0);
			acc(1, ix(IDX_GRP_CFG, n, 4'he), 8'h02, 32'h1, 0, 1);
			acc(0, ix(IDX_GRP_CFG, n, 4'hf), 8'h00, 0,
				32'(VENDOR_MAX_SUB), 0);
			for (int k = 1; k <= 10; k++) begin
				d = $urandom;
				acc(1, ix(IDX_GRP_CFG, n, 4'hf), 8'(k), d, 0, 0);
				acc(0, ix(IDX_GRP_CFG, n, 4'hf), 8'(k), 0,
					{16'h0, d[15:0]}, 0);
			end
		end
		obj.req = 1'b0;
		// Open circuit case, then random traffic with a stalling master
		s = rnd();
		s.over = 1'b1;
		s.error = 1'b1;
		send(s);
		repeat (60) send(rnd());
		smp_valid = 1'b0;
		drain();
		for (int n = 0; n < NCH; n++) begin
			s = last[n];
			acc(0, ix(IDX_GRP_INPUT, n, 4'h0), 8'h01, 0, 32'(s.under), 0);
			acc(0, ix(IDX_GRP_INPUT, n, 4'h0), 8'h02, 0, 32'(s.over), 0);
			acc(0, ix(IDX_GRP_INPUT, n, 4'h0), 8'h07, 0, 32'(s.error), 0);
			acc(0, ix(IDX_GRP_INPUT, n, 4'h0), 8'h0f, 0, 32'(s.error), 0);
			acc(0, ix(IDX_GRP_INPUT, n, 4'h0), 8'h10, 0, 32'(tog[n]), 0);
			acc(0, ix(IDX_GRP_INPUT, n, 4'h0), 8'h11, 0,
				{{16{s.value[15]}}, s.value}, 0);
			acc(0, ix(IDX_GRP_CFG, n, 4'he), 8'h01, 0, s.raw, 0);
			acc(0, ix(IDX_GRP_CFG, n, 4'he), 8'h02, 0,
				{16'h0, s.resistance}, 0);
		end
		obj.req = 1'b0;
		// Fill the record buffer until it refuses, then drain it
		hold = 1'b1;
		repeat (2) @(negedge mclk);
		repeat (FIFO_DEPTH + 1) send(rnd());
		smp_valid = 1'b0;
		@(negedge mclk);
		chk("smp_ready_full", 32'h0, {31'h0, smp_ready});
		hold = 1'b0;
		drain();
		summarize();
	end
endmodule

`default_nettype wire
